// *** include/psm_pkg.sv ***
// Package with register map, field layouts and mode codes of the startup block.
package psm_pkg;

    // ****************************************************************
    // Register map.
    // ****************************************************************
    localparam logic [7:0]  ADDR_STARTUP  = 8'h00; // Startup mode setup word.
    localparam logic [7:0]  ADDR_PERIPH   = 8'h04; // Peripheral port word.
    localparam logic [7:0]  ADDR_RS232    = 8'h08; // Built-in RS-232C word.
    localparam logic [7:0]  ADDR_STATUS   = 8'h0C; // Selection status.
    localparam logic [7:0]  ADDR_INPUTS   = 8'h10; // Live switch view.
    localparam logic [15:0] STARTUP_RST   = 16'h0000; // Startup word reset.
    localparam logic [15:0] PERIPH_RST    = 16'h0000; // Peripheral word reset.
    localparam logic [15:0] RS232_RST     = 16'h0000; // RS-232C word reset.

    // ****************************************************************
    // Field codes.
    // ****************************************************************
    localparam logic [7:0]  SEL_SWITCH    = 8'h00; // Mode from switch 7.
    localparam logic [7:0]  SEL_RESUME    = 8'h01; // Resume last mode.
    localparam logic [7:0]  SEL_LOWBYTE   = 8'h02; // Mode from lower byte.
    localparam logic [7:0]  LOW_PROGRAM   = 8'h00; // Lower byte PROGRAM.
    localparam logic [7:0]  LOW_MONITOR   = 8'h01; // Lower byte MONITOR.
    localparam logic [7:0]  LOW_RUN       = 8'h02; // Lower byte RUN.
    localparam logic [15:0] PERIPH_CUSTOM = 16'h0001; // Custom parameters.
    localparam logic [1:0]  M_PROGRAM     = 2'h0; // Operating mode codes.
    localparam logic [1:0]  M_MONITOR     = 2'h1;
    localparam logic [1:0]  M_RUN         = 2'h2;
    localparam logic [1:0]  P_CONSOLE     = 2'h0; // Peripheral port roles.
    localparam logic [1:0]  P_SETUP       = 2'h1;
    localparam logic [1:0]  P_DEFAULT     = 2'h2;
    localparam logic [1:0]  R_HOSTLINK    = 2'h0; // RS-232C modes.
    localparam logic [1:0]  R_NOPROTO     = 2'h1;
    localparam logic [1:0]  R_DATALINK    = 2'h2;
    localparam logic [1:0]  R_DISPLAY     = 2'h3;
    localparam logic [1:0]  DEV_NONE      = 2'h0; // Attached device kinds.
    localparam logic [1:0]  DEV_CONSOLE   = 2'h1;
    localparam logic [1:0]  DEV_OTHER     = 2'h2;
    // Fixed default framing: host link, 1 start, even, 7 data, 2 stop.
    localparam int          DEF_BAUD      = 9600; // Bit rate in bit/s.
    localparam logic [3:0]  DEF_DATA_BITS = 4'h7; // Data bits.
    localparam logic [1:0]  DEF_STOP_BITS = 2'h2; // Stop bits.
    localparam logic        DEF_PARITY_EV = 1'b1; // Even parity.

    // Selections registered when the selection machine leaves detect.
    typedef struct packed {
        logic [1:0] op_mode;    // Operating mode.
        logic [1:0] periph;     // Peripheral port role.
        logic       periph_cus; // Peripheral custom parameters.
        logic       rs_forced;  // RS-232C forced to defaults.
        logic [1:0] rs_mode;    // RS-232C serial mode.
        logic       console_ok; // Console link allowed.
        logic       other_ok;   // Non-console link allowed.
        logic       xi_restore; // Restore expansion defaults.
        logic       xi_cassette;// Expansion cassette transfer allowed.
    } psm_sel_t;

    // Front switch bank, raw.
    typedef struct packed {
        logic [7:0] pin; // pin[0] is switch 1.
    } psm_sw_t;
endpackage : psm_pkg

// *** hdl/psm_top.sv ***
// Port and startup mode selection with its APB register file.
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
// Contract
// - 5 off, 7 on: peripheral uses setup words
// - 5 and 7 on: peripheral uses defaults
// - 7 off: peripheral is console bus only
// - 5 off: RS-232C mode from setup words
// - 5 on: RS-232C forced host link defaults
// - Upper byte picks switch, resume, lower
// - Lower byte: PROGRAM, MONITOR, RUN
// - Nothing attached: 7 off PROGRAM, on RUN
// - Console: selector if 7 off, else PROGRAM
// - Other device, 7 off: PROGRAM, refused
// - Other device, 7 on: mode by cable
// - Mode fixed after console detection if upper byte is 00, at once for any other upper byte
// - Switch 4 on keeps user expansion codes
// - Switch 4 off restores defaults, skips cassette
// - Switch 6 mirrored in option status bit
// - Defaults: host link, 7E2 framing, 9600
module psm_top (
    input  wire logic               pclk,          // System clock.
    input  wire logic               presetn,       // Async reset, low.
    input  wire logic [31:0]        paddr,         // APB address.
    input  wire logic               psel,          // APB select.
    input  wire logic               penable,       // APB enable.
    input  wire logic               pwrite,        // APB direction.
    input  wire logic [31:0]        pwdata,        // APB write data.
    output logic      [31:0]        prdata,        // APB read data.
    output logic                    pready,        // APB ready.
    output logic                    pslverr,       // APB error.
    input  wire psm_pkg::psm_sw_t   sw_pins,       // Front switches.
    input  wire logic [1:0]         dev_kind,      // Attached device kind.
    input  wire logic               dev_valid,     // Detection finished.
    input  wire logic               cable_run,     // Cable asks for RUN.
    input  wire logic [1:0]         console_mode,  // Console selector.
    input  wire logic [1:0]         last_mode,     // Mode at last power off.
    output psm_pkg::psm_sel_t       sel,           // Registered selections.
    output logic                    sel_valid,     // Selections fixed.
    output logic                    user_option_status_bit // Switch 6 copy.
);

    // ****************************************************************
    // Switch synchronisers.
    // ****************************************************************
    logic [7:0] sw_s1;      // First stage, read only by second stage.
    logic [7:0] sw_s2;      // Second stage.
    logic [7:0] sw_s3;      // Third stage.
    logic [7:0] sw_q;       // Accepted switch state.
    logic [7:0] next_sw_q;  // Next accepted switch state.
    logic [2:0] dv_s;       // Detection flag synchroniser.

    // Accept a switch change once stages two and three agree; a bounce
    // that shows in only one stage leaves the accepted bit alone.
    for (genvar gi = 0; gi < 8; gi++) begin : g_sw_accept
        assign next_sw_q[gi] = (sw_s2[gi] == sw_s3[gi]) ? sw_s3[gi]
                                                        : sw_q[gi];
    end

    // Registers the switch pipeline.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_s1 <= 8'h00;
            sw_s2 <= 8'h00;
            sw_s3 <= 8'h00;
            sw_q  <= 8'h00;
            dv_s  <= 3'h0;
        end else begin
            sw_s1 <= sw_pins.pin;
            sw_s2 <= sw_s1;
            sw_s3 <= sw_s2;
            sw_q  <= next_sw_q;
            dv_s  <= {dv_s[1:0], dev_valid};
        end
    end

    // Stable detection flag, from agreeing late stages.
    logic dv_ok;
    assign dv_ok = dv_s[1] & dv_s[2];

    // ****************************************************************
    // Register file.
    // ****************************************************************
    logic [15:0] startup_mode_setup_word;      // Startup setup word.
    logic [15:0] periph_word;                  // Peripheral port word.
    logic [15:0] rs_word;                      // RS-232C word.
    logic [15:0] next_startup;                 // Next startup word.
    logic [15:0] next_periph;                  // Next peripheral word.
    logic [15:0] next_rs;                      // Next RS-232C word.
    logic [31:0] next_prdata;                  // Next read data.
    logic        next_pslverr;                 // Next error.
    logic        next_pready;                  // Next ready.
    logic        setup_ph;                     // APB setup phase.
    logic [7:0]  addr_lo;                      // Decoded address.

    assign setup_ph = psel & ~penable;
    assign addr_lo  = paddr[7:0];

    // Decodes the bus; answers in the access cycle, no wait state.
    always_comb begin
        next_startup = startup_mode_setup_word;
        next_periph  = periph_word;
        next_rs      = rs_word;
        next_prdata  = 32'h0000_0000;
        next_pslverr = 1'b0;
        next_pready  = setup_ph;
        if (setup_ph) begin
            case (addr_lo)
                psm_pkg::ADDR_STARTUP: begin
                    next_prdata = {16'h0000, startup_mode_setup_word};
                    if (pwrite) next_startup = pwdata[15:0];
                end
                psm_pkg::ADDR_PERIPH: begin
                    next_prdata = {16'h0000, periph_word};
                    if (pwrite) next_periph = pwdata[15:0];
                end
                psm_pkg::ADDR_RS232: begin
                    next_prdata = {16'h0000, rs_word};
                    if (pwrite) next_rs = pwdata[15:0];
                end
                psm_pkg::ADDR_STATUS: begin
                    next_prdata = {19'h0_0000, sel_valid, sel};
                    next_pslverr = pwrite;
                end
                psm_pkg::ADDR_INPUTS: begin
                    next_prdata = {24'h00_0000, sw_q};
                    next_pslverr = pwrite;
                end
                default: begin
                    next_pslverr = 1'b1;
                end
            endcase
        end
    end

    // Staged words, caught in the setup cycle of a transfer.
    logic [15:0] pend_startup; // Staged startup word.
    logic [15:0] pend_periph;  // Staged peripheral word.
    logic [15:0] pend_rs;      // Staged RS-232C word.
    logic        commit;       // Access cycle that is allowed to write.
    logic [15:0] next_word_st; // Next startup word.
    logic [15:0] next_word_pe; // Next peripheral word.
    logic [15:0] next_word_rs; // Next RS-232C word.

    // A refused access must not change any word, so a staged value only
    // lands at the edge that ends a clean access cycle.
    assign commit = psel & penable & pready & ~pslverr;

    // Picks the words that the edge ending the access cycle will hold.
    always_comb begin
        next_word_st = startup_mode_setup_word;
        next_word_pe = periph_word;
        next_word_rs = rs_word;
        if (commit) begin
            next_word_st = pend_startup;
            next_word_pe = pend_periph;
            next_word_rs = pend_rs;
        end
    end

    // Registers the bus state; writes land in the access cycle edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            startup_mode_setup_word <= psm_pkg::STARTUP_RST;
            periph_word  <= psm_pkg::PERIPH_RST;
            rs_word      <= psm_pkg::RS232_RST;
            pend_startup <= psm_pkg::STARTUP_RST;
            pend_periph  <= psm_pkg::PERIPH_RST;
            pend_rs      <= psm_pkg::RS232_RST;
            prdata       <= 32'h0000_0000;
            pslverr      <= 1'b0;
            pready       <= 1'b0;
        end else begin
            pend_startup <= next_startup;
            pend_periph  <= next_periph;
            pend_rs      <= next_rs;
            startup_mode_setup_word <= next_word_st;
            periph_word  <= next_word_pe;
            rs_word      <= next_word_rs;
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
            pready  <= next_pready;
        end
    end

    // ****************************************************************
    // Selection machine.
    // ****************************************************************
    typedef enum logic [1:0] {
        PSM_SETTLE, PSM_DETECT, PSM_HOLD
    } psm_state_t;

    psm_state_t         state;       // Machine state.
    psm_state_t         next_state;  // Next machine state.
    psm_pkg::psm_sel_t  next_sel;    // Next selections.
    psm_pkg::psm_sel_t  calc;        // Selections from live inputs.
    logic               next_valid;  // Next valid flag.
    logic [7:0]         up;          // Upper byte of startup word.
    logic [7:0]         lo;          // Lower byte of startup word.
    logic               s4;          // Switch 4.
    logic               s5;          // Switch 5.
    logic               s7;          // Switch 7.

    assign up = startup_mode_setup_word[15:8];
    assign lo = startup_mode_setup_word[7:0];
    assign s4 = sw_q[3];
    assign s5 = sw_q[4];
    assign s7 = sw_q[6];

    // Works out port roles and startup mode from inputs.
    always_comb begin
        calc = '0;
        // Peripheral port role.
        if (!s7) begin
            calc.periph     = psm_pkg::P_CONSOLE;
            calc.console_ok = 1'b1;
        end else if (s5) begin
            calc.periph   = psm_pkg::P_DEFAULT;
            calc.other_ok = 1'b1;
        end else begin
            calc.periph     = psm_pkg::P_SETUP;
            calc.other_ok   = 1'b1;
            calc.periph_cus = (periph_word == psm_pkg::PERIPH_CUSTOM);
        end
        // RS-232C port mode.
        if (s5) begin
            calc.rs_forced = 1'b1;
            calc.rs_mode   = psm_pkg::R_HOSTLINK;
        end else begin
            calc.rs_mode   = rs_word[1:0];
        end
        // Expansion instruction handling.
        calc.xi_restore  = ~s4;
        calc.xi_cassette = s4;
        // Startup mode.
        case (up)
            psm_pkg::SEL_RESUME: calc.op_mode = last_mode;
            psm_pkg::SEL_LOWBYTE: begin
                case (lo)
                    psm_pkg::LOW_MONITOR: calc.op_mode = psm_pkg::M_MONITOR;
                    psm_pkg::LOW_RUN:     calc.op_mode = psm_pkg::M_RUN;
                    default:              calc.op_mode = psm_pkg::M_PROGRAM;
                endcase
            end
            default: begin
                case (dev_kind)
                    psm_pkg::DEV_CONSOLE: begin
                        calc.op_mode = s7 ? psm_pkg::M_PROGRAM
                                          : console_mode;
                        if (s7) calc.other_ok = 1'b0;
                    end
                    psm_pkg::DEV_OTHER: begin
                        if (!s7) begin
                            calc.op_mode    = psm_pkg::M_PROGRAM;
                            calc.console_ok = 1'b0;
                        end else begin
                            calc.op_mode = cable_run ? psm_pkg::M_RUN
                                                     : psm_pkg::M_PROGRAM;
                        end
                    end
                    default: calc.op_mode = s7 ? psm_pkg::M_RUN
                                               : psm_pkg::M_PROGRAM;
                endcase
            end
        endcase
    end

    // With the upper byte 00, the machine waits in detect for the synchronised detection flag, so
    // a device that answers late can never leave the mode half decided.
    // Steps from settle to detect to hold; hold lasts until reset.
    always_comb begin
        next_state = state;
        next_sel   = sel;
        next_valid = sel_valid;
        case (state)
            PSM_SETTLE: next_state = PSM_DETECT;
            PSM_DETECT: begin
                if (dv_ok || up != psm_pkg::SEL_SWITCH) begin
                    next_sel   = calc;
                    next_valid = 1'b1;
                    next_state = PSM_HOLD;
                end
            end
            PSM_HOLD: next_state = PSM_HOLD;
            default:  next_state = PSM_SETTLE;
        endcase
    end

    // Registers the machine and its outputs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= PSM_SETTLE;
            sel       <= '0;
            sel_valid <= 1'b0;
            user_option_status_bit <= 1'b0;
        end else begin
            state     <= next_state;
            sel       <= next_sel;
            sel_valid <= next_valid;
            user_option_status_bit <= sw_q[5];
        end
    end

endmodule // psm_top

// *** testbench/psm_top_props.sv ***
// Checker of the port and startup selections, bound to the top module.
`timescale 1ns/1ns
module psm_top_props (
    input wire logic             pclk,      // System clock.
    input wire logic             presetn,   // Async reset, low.
    input wire logic [31:0]      paddr,     // APB address.
    input wire logic             psel,      // APB select.
    input wire logic             penable,   // APB enable.
    input wire logic             pwrite,    // APB direction.
    input wire logic             pready,    // APB ready.
    input wire logic             pslverr,   // APB error.
    input wire psm_pkg::psm_sw_t sw_pins,   // Front switches.
    input wire logic [1:0]       dev_kind,  // Attached device kind.
    input wire psm_pkg::psm_sel_t sel,      // Registered selections.
    input wire logic             sel_valid, // Selections fixed.
    input wire logic             user_option_status_bit // Switch 6 copy.
);
    wire [7:0] sw = sw_pins.pin; // Switch n sits at bit n-1.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_HOLD: assert property (sel_valid |=> sel_valid && $stable(sel))
        else $error("selection moved after lock");
    AST_RS_FORCED: assert property (sel_valid && sw[4] |->
        sel.rs_forced && sel.rs_mode == psm_pkg::R_HOSTLINK)
        else $error("serial port not forced to defaults");
    AST_CONSOLE_ONLY: assert property (sel_valid && !sw[6] |->
        sel.periph == psm_pkg::P_CONSOLE && !sel.other_ok)
        else $error("peripheral port not console only");
    AST_PERIPH_DEF: assert property (sel_valid && sw[4] && sw[6] |->
        sel.periph == psm_pkg::P_DEFAULT)
        else $error("peripheral port not on defaults");
    AST_PERIPH_SETUP: assert property (sel_valid && !sw[4] && sw[6] |->
        sel.periph == psm_pkg::P_SETUP)
        else $error("peripheral port not on setup words");
    AST_XI_RESTORE: assert property (sel_valid && !sw[3] |->
        sel.xi_restore && !sel.xi_cassette)
        else $error("expansion defaults not restored");
    AST_XI_KEEP: assert property (sel_valid && sw[3] |-> !sel.xi_restore)
        else $error("expansion codes restored with switch 4 on");
    AST_NO_CONSOLE: assert property (sel_valid && sw[6] &&
        dev_kind == psm_pkg::DEV_CONSOLE |-> !sel.console_ok)
        else $error("console talks with switch 7 on");
    AST_OPTION: assert property ($stable(sw[5])[*8] |->
        user_option_status_bit == sw[5])
        else $error("option bit does not follow switch 6");
    AST_APB_ANSWER: assert property (psel && !penable |=> pready)
        else $error("no answer in access cycle");
    AST_RO_WRITE: assert property (psel && penable && pready && pwrite &&
        paddr[7:0] == psm_pkg::ADDR_STATUS |-> pslverr)
        else $error("status write not refused");
    cover property ($rose(sel_valid) && sel.op_mode == psm_pkg::M_RUN);
    cover property ($rose(sel_valid) && sel.op_mode == psm_pkg::M_MONITOR);
    cover property (psel && penable && pready && pslverr);
endmodule // psm_top_props

bind psm_top psm_top_props u_props (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .pslverr(pslverr), .sw_pins(sw_pins),
    .dev_kind(dev_kind), .sel(sel), .sel_valid(sel_valid),
    .user_option_status_bit(user_option_status_bit));

// *** testbench/psm_console_model.sv ***
// Model of the device attached to the peripheral port.
`timescale 1ns/1ns
module psm_console_model (
    input  wire logic       pclk,         // System clock.
    input  wire logic       presetn,      // Async reset, low.
    input  wire logic       go,           // Start detection.
    input  wire logic       slow,         // Detect slowly.
    input  wire logic [1:0] kind,         // Kind to report.
    input  wire logic       run_cable,    // Cable type asks for RUN.
    input  wire logic [1:0] selector,     // Console mode selector.
    output logic [1:0]      dev_kind,     // Reported kind.
    output logic            dev_valid,    // Detection finished.
    output logic            cable_run,    // Reported cable type.
    output logic [1:0]      console_mode  // Reported selector.
);
    logic [3:0] cnt; // Free running, feeds the wander pattern.
    logic [3:0] dly; // Detection wait.
    // Detection ends two or eight cycles after go.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 4'h0;
            dly <= 4'h0;
            dev_valid <= 1'b0;
        end else begin
            cnt <= cnt + 4'h1;
            if (go && !dev_valid) begin
                dly <= dly + 4'h1;
                dev_valid <= (dly >= (slow ? 4'h7 : 4'h1));
            end
        end
    end
    // Until detection ends the lines wander, so nothing early is trusted.
    assign dev_kind = dev_valid ? kind : ~cnt[1:0];
    assign cable_run = dev_valid ? run_cable : cnt[0];
    assign console_mode = dev_valid ? selector : cnt[2:1];
endmodule // psm_console_model

// *** testbench/tb.sv ***
// Self-checking bench of the port and startup selection block.
`timescale 1ns/1ns
module tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
    logic pready, pslverr, sel_valid, uosb, err, dev_valid, cable_run;
    logic go = 0, slow = 0, run_cable = 0;
    logic [1:0] dev_kind, console_mode, kind = 0, selector = 0, last_mode = 0;
    psm_pkg::psm_sw_t sw_pins = '0;
    psm_pkg::psm_sel_t sel;
    int bad_count = 0, cmp_count = 0, cycles = 0;
    always #50 pclk = ~pclk;
    psm_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sw_pins(sw_pins),
        .dev_kind(dev_kind), .dev_valid(dev_valid), .cable_run(cable_run),
        .console_mode(console_mode), .last_mode(last_mode), .sel(sel),
        .sel_valid(sel_valid), .user_option_status_bit(uosb));
    psm_console_model u_dev (.pclk(pclk), .presetn(presetn), .go(go),
        .slow(slow), .kind(kind), .run_cable(run_cable), .selector(selector),
        .dev_kind(dev_kind), .dev_valid(dev_valid), .cable_run(cable_run),
        .console_mode(console_mode));
    task finish_test;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // A hang ends the run as a mismatch.
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            finish_test();
        end
    end
    task check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One APB transfer; the answer is taken at the edge that sees pready.
    task apb(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w;
        paddr <= {24'h0000_00, a}; pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1;
        do begin @(posedge pclk); end while (pready !== 1'b1);
        rd = prdata; err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    // Mode codes: 0 PROGRAM, 1 MONITOR, 2 RUN; port roles 0/1/2.
    task run_case(input logic [7:0] sw, input logic [15:0] st, pw, rw,
        input logic [1:0] dk, input logic cb, input logic [1:0] cm, lm,
        input logic [1:0] eop, ep, er);
        int n;
        @(posedge pclk);
        presetn <= 0; go <= 0; kind <= dk; run_cable <= cb;
        sw_pins <= sw & 8'h7F;
        selector <= cm; last_mode <= lm; slow <= ~slow;
        repeat (20) @(posedge pclk);
        presetn <= 1;
        apb(0, psm_pkg::ADDR_STARTUP, 16'h0000);
        check(rd, {16'h0000, psm_pkg::STARTUP_RST});
        apb(1, psm_pkg::ADDR_PERIPH, pw);
        apb(1, psm_pkg::ADDR_RS232, rw);
        apb(1, psm_pkg::ADDR_STARTUP, st);
        if (st[15:8] == 8'h00) check(sel_valid, 0);
        go <= 1;
        n = 0;
        while (sel_valid !== 1'b1 && n < 60) begin @(posedge pclk); n++; end
        check(sel_valid, 1);
        check(sel.op_mode, eop);
        check(sel.periph, ep);
        check(sel.rs_mode, er);
        if (ep == 2'h1) check(sel.periph_cus, pw[0]);
        check(sel.xi_restore, !sw[3]);
        check(sel.rs_forced, sw[4]);
        check(uosb, sw[5]);
        apb(1, psm_pkg::ADDR_STARTUP, ~st);
        @(posedge pclk);
        check(sel.op_mode, eop);
        apb(0, psm_pkg::ADDR_STATUS, 16'h0000);
        check(rd[12:0], {1'b1, sel});
        check(rd[12:8], {1'b1, eop, ep});
    endtask
    initial begin
        run_case(8'h00, 16'h0000, 16'h0000, 16'h0001, 0, 0, 0, 0, 0, 0, 1);
        run_case(8'h68, 16'h0000, 16'h0001, 16'h0003, 0, 0, 0, 0, 2, 1, 3);
        run_case(8'h20, 16'h0000, 16'h0000, 16'h0002, 1, 0, 1, 0, 1, 0, 2);
        run_case(8'h50, 16'h0000, 16'h0001, 16'h0002, 1, 0, 2, 0, 0, 2, 0);
        run_case(8'h10, 16'h0000, 16'h0000, 16'h0003, 2, 1, 0, 0, 0, 0, 0);
        run_case(8'h48, 16'h0000, 16'h0000, 16'h0000, 2, 1, 0, 0, 2, 1, 0);
        run_case(8'h40, 16'h0000, 16'h0001, 16'h0001, 2, 0, 0, 0, 0, 1, 1);
        run_case(8'h00, 16'h0201, 16'h0000, 16'h0000, 0, 0, 0, 0, 1, 0, 0);
        run_case(8'h40, 16'h0200, 16'h0000, 16'h0000, 0, 0, 0, 0, 0, 1, 0);
        run_case(8'h00, 16'h0202, 16'h0000, 16'h0000, 0, 0, 0, 0, 2, 0, 0);
        run_case(8'h00, 16'h0100, 16'h0000, 16'h0000, 0, 0, 0, 2, 2, 0, 0);
        run_case(8'h40, 16'h0100, 16'h0000, 16'h0000, 0, 0, 0, 1, 1, 1, 0);
        apb(0, 8'h20, 16'h0000);
        check(err, 1);
        apb(1, psm_pkg::ADDR_STATUS, 16'hFFFF);
        check(err, 1);
        finish_test();
    end
endmodule // tb
